//--- include/sas_pkg.sv
// Constants, register map and carrier types of the converter sequencer.
// Assumes a single 125 MHz core clock and a 32-bit AHB-Lite register bus.
package sas_pkg;
  // Converter and channel geometry
  localparam int RES_W = 12;
  localparam int NCH = 17;
  localparam int CH_W = 5;
  localparam logic [4:0] TEMP_CH = 5'h10;
  localparam logic [4:0] BASE_CHS = 5'h08;
  // Timing: the conversion clock is divided down from the core clock
  localparam int CORE_CLK_KHZ = 125000;
  localparam int CONV_CLK_MAX_KHZ = 18000;
  localparam int CONV_DIV =
    (CORE_CLK_KHZ + CONV_CLK_MAX_KHZ - 1) / CONV_CLK_MAX_KHZ;
  localparam int CONV_CLKS = 18;
  // Register byte offsets (9-bit decode)
  localparam int ADDR_W = 9;
  localparam logic [8:0] OFF_CTRL = 9'h000;
  localparam logic [8:0] OFF_CHEN = 9'h004;
  localparam logic [8:0] OFF_LIMIT = 9'h008;
  localparam logic [8:0] OFF_STAT = 9'h00C;
  localparam logic [8:0] OFF_INTST = 9'h010;
  localparam logic [8:0] OFF_INTCLR = 9'h014;
  localparam logic [8:0] OFF_INTEN = 9'h018;
  localparam logic [8:0] OFF_RANGE = 9'h01C;
  localparam logic [8:0] OFF_SWITCH = 9'h020;
  localparam logic [1:0] RGN_CTRL = 2'h0;
  localparam logic [1:0] RGN_SMP = 2'h1;
  localparam logic [1:0] RGN_RES = 2'h2;
  // Control register fields
  localparam int CTRL_EN = 0;
  localparam int CTRL_START = 1;
  localparam int CTRL_CONT = 2;
  localparam int CTRL_FW = 3;
  localparam int CTRL_FWCH = 4;
  localparam int CTRL_REF = 9;
  localparam int CTRL_TBIAS = 11;
  localparam int CTRL_EXT16 = 12;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CHEN_RST = 32'h0000_0001;
  localparam int LIM_LO = 0;
  localparam int LIM_HI = 16;
  localparam logic [31:0] LIMIT_RST = 32'h0FFF_0000;
  localparam logic [7:0] SMP_RST = 8'h03;
  localparam int RES_VALID = 31;
  localparam int STAT_BUSY = 0;
  localparam int STAT_CH = 1;
  localparam int SW_SEQ = 8;
  // Interrupt status bits
  localparam int INT_DONE = 0;
  localparam int INT_RANGE = 1;
  // Reference choices
  localparam logic [1:0] REF_VDD = 2'h0;
  localparam logic [1:0] REF_HALF = 2'h1;
  localparam logic [1:0] REF_INT = 2'h2;
  localparam logic [1:0] REF_EXT = 2'h3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONV = 2'b10
  } sas_state_t;

  typedef struct packed {
    logic [4:0] mux_sel;
    logic [1:0] ref_sel;
    logic sample;
    logic temp_bias_en;
    logic [11:0] dac_code;
    logic sar_clk;
  } sas_ana_t;
endpackage

//--- design/sas_top.sv
// Scan sequencer and SAR control logic for a 12-bit converter.
// Assumes an AHB-Lite master, a comparator output synchronous to CORE_CLK
// and an analogue front end that follows the packed control bundle.
// Contract
// - Results are 12 bits; conversion clock divided to at most 18 MHz.
// - Each conversion spans at least 18 conversion clocks before valid.
// - Eight input channels, extendable to sixteen by a control bit.
// - Once started, the sequencer walks all enabled channels unaided.
// - No idle slot between channels; throughput same for one or many.
// - Channel chosen by the sequencer or by firmware, per mode bit.
// - Every channel keeps its own latest result buffer.
// - Each channel has its own programmable sample duration.
// - Programmable low and high limit values are held.
// - Out-of-range interrupt raised per result, not at scan end.
// - Reference selects supply, half supply, 1.024 V internal or external.
// - Sample-and-hold window length is programmable.
// - Temperature sensor is selectable as a converter input.
// - No conversions while the chip is in its deepest low-power modes.
// - Sequencer may drive the opamp switches beside firmware and logic.
// - Temperature sensor bias current can be disabled.
`timescale 1ns/100ps
module sas_top (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RESETN,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Analogue front end
  output sas_pkg::sas_ana_t ANA,
  input wire logic COMP_HI,
  // Opamp routing switches
  input wire logic [7:0] PLD_SW,
  output logic [7:0] OA_SW,
  // Power state and interrupt
  input wire logic LOW_POWER_MODE,
  output logic IRQ
);
  localparam int NCH = sas_pkg::NCH;
  localparam int RES_W = sas_pkg::RES_W;

  logic rst_meta_q;
  logic rst_n_q;
  logic [31:0] ctrl_q;
  logic [NCH-1:0] chen_q;
  logic [31:0] limit_q;
  logic [15:0] sw_q;
  logic [1:0] ist_q;
  logic [1:0] ien_q;
  logic [NCH-1:0] range_q;
  logic [7:0] smp_q [NCH];
  logic [RES_W-1:0] res_q [NCH];
  logic [NCH-1:0] valid_q;
  logic wr_q;
  logic [8:0] waddr_q;
  logic [31:0] rdata_q;
  logic [31:0] rd_d;
  logic [3:0] div_q;
  logic sar_clk_q;
  sas_pkg::sas_state_t state_q;
  logic [4:0] cur_q;
  logic [7:0] smp_cnt_q;
  logic [4:0] bit_q;
  logic [RES_W-1:0] dac_q;
  logic done_q;

  // Reset release through two flops
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // Bus decode
  logic addr_ok;
  logic wr_en;
  logic [4:0] widx;
  logic [1:0] wrgn;
  logic start_p;
  assign addr_ok = HSEL & HTRANS[1] & HREADY;
  assign wr_en = wr_q;
  assign widx = waddr_q[6:2];
  assign wrgn = waddr_q[8:7];
  assign start_p = wr_en && waddr_q == sas_pkg::OFF_CTRL &&
                   HWDATA[sas_pkg::CTRL_START];
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign HRDATA = rdata_q;

  always_ff @(posedge CORE_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wr_q <= 1'b0;
      waddr_q <= 9'h000;
      rdata_q <= 32'h0000_0000;
    end else begin
      wr_q <= addr_ok & HWRITE;
      if (addr_ok) begin
        waddr_q <= HADDR[8:0];
      end
      if (addr_ok && !HWRITE) begin
        rdata_q <= rd_d;
      end
    end
  end

  // Read mux; unmapped words read as zero
  always_comb begin
    logic [4:0] ridx;
    ridx = HADDR[6:2];
    rd_d = 32'h0000_0000;
    unique case (HADDR[8:7])
      sas_pkg::RGN_CTRL: begin
        unique case ({2'b00, HADDR[6:0]})
          sas_pkg::OFF_CTRL: rd_d = ctrl_q;
          sas_pkg::OFF_CHEN: rd_d = {15'h0000, chen_q};
          sas_pkg::OFF_LIMIT: rd_d = limit_q;
          sas_pkg::OFF_STAT: begin
            rd_d[sas_pkg::STAT_BUSY] = state_q != sas_pkg::ST_IDLE;
            rd_d[sas_pkg::STAT_CH +: 5] = cur_q;
          end
          sas_pkg::OFF_INTST: rd_d = {30'h0000_0000, ist_q};
          sas_pkg::OFF_INTEN: rd_d = {30'h0000_0000, ien_q};
          sas_pkg::OFF_RANGE: rd_d = {15'h0000, range_q};
          sas_pkg::OFF_SWITCH: rd_d = {16'h0000, sw_q};
          default: rd_d = 32'h0000_0000;
        endcase
      end
      sas_pkg::RGN_SMP: begin
        if (ridx < 5'(NCH)) begin
          rd_d = {24'h00_0000, smp_q[ridx]};
        end
      end
      sas_pkg::RGN_RES: begin
        if (ridx < 5'(NCH)) begin
          rd_d[RES_W-1:0] = res_q[ridx];
          rd_d[sas_pkg::RES_VALID] = valid_q[ridx];
        end
      end
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // Configuration registers; the start bit is a strobe and never stored
  always_ff @(posedge CORE_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ctrl_q <= sas_pkg::CTRL_RST;
      chen_q <= sas_pkg::CHEN_RST[NCH-1:0];
      limit_q <= sas_pkg::LIMIT_RST;
      sw_q <= 16'h0000;
      ien_q <= 2'h0;
    end else if (wr_en && wrgn == sas_pkg::RGN_CTRL) begin
      unique case (waddr_q)
        sas_pkg::OFF_CTRL: begin
          ctrl_q <= HWDATA;
          ctrl_q[sas_pkg::CTRL_START] <= 1'b0;
        end
        sas_pkg::OFF_CHEN: chen_q <= HWDATA[NCH-1:0];
        sas_pkg::OFF_LIMIT: begin
          limit_q <= HWDATA & sas_pkg::LIMIT_RST | HWDATA & 32'h0000_0FFF;
        end
        sas_pkg::OFF_SWITCH: sw_q <= HWDATA[15:0];
        sas_pkg::OFF_INTEN: ien_q <= HWDATA[1:0];
        default: ;
      endcase
    end
  end

  // Per-channel sample times
  always_ff @(posedge CORE_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      for (int i = 0; i < NCH; i++) begin
        smp_q[i] <= sas_pkg::SMP_RST;
      end
    end else if (wr_en && wrgn == sas_pkg::RGN_SMP && widx < 5'(NCH)) begin
      smp_q[widx] <= HWDATA[7:0];
    end
  end

  // Conversion clock: core clock divided so it never passes 18 MHz
  logic tick;
  assign tick = div_q == 4'(sas_pkg::CONV_DIV - 1);
  always_ff @(posedge CORE_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      div_q <= 4'h0;
      sar_clk_q <= 1'b0;
    end else begin
      div_q <= tick ? 4'h0 : div_q + 4'h1;
      sar_clk_q <= div_q < 4'(sas_pkg::CONV_DIV / 2);
    end
  end

  // Channel selection helpers
  logic ext16;
  logic fw_mode;
  logic run_ok;
  logic [NCH-1:0] mask;
  logic [4:0] fw_ch;
  assign ext16 = ctrl_q[sas_pkg::CTRL_EXT16];
  assign fw_mode = ctrl_q[sas_pkg::CTRL_FW];
  assign mask = chen_q & {1'b1, {8{ext16}}, 8'hFF};
  assign run_ok = ctrl_q[sas_pkg::CTRL_EN] & ~LOW_POWER_MODE;
  assign fw_ch = (ctrl_q[sas_pkg::CTRL_FWCH +: 5] >= 5'(NCH) ||
                  (!ext16 && ctrl_q[sas_pkg::CTRL_FWCH +: 5] >=
                   sas_pkg::BASE_CHS &&
                   ctrl_q[sas_pkg::CTRL_FWCH +: 5] != sas_pkg::TEMP_CH)) ?
                 sas_pkg::TEMP_CH : ctrl_q[sas_pkg::CTRL_FWCH +: 5];

  function automatic logic [5:0] next_ch(input logic [NCH-1:0] m,
                                         input logic [5:0] s);
    logic [5:0] r;
    r = 6'h00;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (6'(i) >= s && m[i]) begin
        r = {1'b1, 5'(i)};
      end
    end
    return r;
  endfunction

  logic [5:0] nx_after;
  logic [5:0] nx_first;
  logic conv_end;
  assign nx_after = next_ch(mask, {1'b0, cur_q} + 6'h01);
  assign nx_first = next_ch(mask, 6'h00);
  assign conv_end = state_q == sas_pkg::ST_CONV && tick &&
                    bit_q == 5'(sas_pkg::CONV_CLKS - 1);

  // Sequencer and successive approximation
  always_ff @(posedge CORE_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= sas_pkg::ST_IDLE;
      cur_q <= 5'h00;
      smp_cnt_q <= 8'h00;
      bit_q <= 5'h00;
      dac_q <= 12'h000;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (!run_ok) begin
        state_q <= sas_pkg::ST_IDLE;
      end else begin
        unique case (state_q)
          sas_pkg::ST_IDLE: begin
            if (start_p && fw_mode) begin
              cur_q <= fw_ch;
              smp_cnt_q <= smp_q[fw_ch];
              state_q <= sas_pkg::ST_SAMPLE;
            end else if (start_p && nx_first[5]) begin
              cur_q <= nx_first[4:0];
              smp_cnt_q <= smp_q[nx_first[4:0]];
              state_q <= sas_pkg::ST_SAMPLE;
            end
          end
          sas_pkg::ST_SAMPLE: begin
            // A zero sample time still holds for one conversion clock
            if (tick) begin
              if (smp_cnt_q <= 8'h01) begin
                state_q <= sas_pkg::ST_CONV;
                bit_q <= 5'h00;
                dac_q <= 12'h800;
              end else begin
                smp_cnt_q <= smp_cnt_q - 8'h01;
              end
            end
          end
          sas_pkg::ST_CONV: begin
            if (tick) begin
              bit_q <= bit_q + 5'h01;
              if (bit_q < 5'(RES_W)) begin
                dac_q[4'(RES_W - 1) - bit_q[3:0]] <= COMP_HI;
                if (bit_q < 5'(RES_W - 1)) begin
                  dac_q[4'(RES_W - 2) - bit_q[3:0]] <= 1'b1;
                end
              end
              if (conv_end) begin
                if (!fw_mode && nx_after[5]) begin
                  // Next channel samples at once: no idle slot
                  cur_q <= nx_after[4:0];
                  smp_cnt_q <= smp_q[nx_after[4:0]];
                  state_q <= sas_pkg::ST_SAMPLE;
                end else begin
                  done_q <= 1'b1;
                  if (!fw_mode && ctrl_q[sas_pkg::CTRL_CONT] &&
                      nx_first[5]) begin
                    cur_q <= nx_first[4:0];
                    smp_cnt_q <= smp_q[nx_first[4:0]];
                    state_q <= sas_pkg::ST_SAMPLE;
                  end else begin
                    state_q <= sas_pkg::ST_IDLE;
                  end
                end
              end
            end
          end
          default: state_q <= sas_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // Result buffers and limit check
  logic out_rng;
  logic [RES_W-1:0] lo;
  logic [RES_W-1:0] hi;
  assign lo = limit_q[sas_pkg::LIM_LO +: RES_W];
  assign hi = limit_q[sas_pkg::LIM_HI +: RES_W];
  assign out_rng = conv_end && (dac_q < lo || dac_q > hi);

  always_ff @(posedge CORE_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      for (int i = 0; i < NCH; i++) begin
        res_q[i] <= 12'h000;
      end
      valid_q <= '0;
    end else if (conv_end) begin
      res_q[cur_q] <= dac_q;
      valid_q[cur_q] <= 1'b1;
    end
  end

  // Per-channel range flags, write one to clear; a new trip wins
  logic [NCH-1:0] rng_set;
  logic [NCH-1:0] rng_clr;
  assign rng_set = out_rng ? NCH'(1) << cur_q : '0;
  assign rng_clr = (wr_en && waddr_q == sas_pkg::OFF_RANGE) ?
                   HWDATA[NCH-1:0] : '0;
  always_ff @(posedge CORE_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      range_q <= '0;
    end else begin
      range_q <= (range_q & ~rng_clr) | rng_set;
    end
  end

  // Sticky interrupt status; set wins over clear
  logic [1:0] ist_set;
  logic [1:0] ist_clr;
  assign ist_set = {out_rng, done_q};
  assign ist_clr = (wr_en && waddr_q == sas_pkg::OFF_INTCLR) ?
                   HWDATA[1:0] : 2'h0;
  always_ff @(posedge CORE_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ist_q <= 2'h0;
      IRQ <= 1'b0;
    end else begin
      ist_q <= (ist_q & ~ist_clr) | ist_set;
      IRQ <= |(((ist_q & ~ist_clr) | ist_set) & ien_q);
    end
  end

  // Analogue control bundle
  logic busy;
  assign busy = state_q != sas_pkg::ST_IDLE;
  always_comb begin
    ANA.mux_sel = cur_q;
    ANA.ref_sel = ctrl_q[sas_pkg::CTRL_REF +: 2];
    ANA.sample = state_q == sas_pkg::ST_SAMPLE;
    ANA.temp_bias_en = ctrl_q[sas_pkg::CTRL_TBIAS];
    ANA.dac_code = dac_q;
    ANA.sar_clk = sar_clk_q;
  end

  // Firmware, programmable logic and sequencer all steer the switches
  assign OA_SW = sw_q[7:0] | PLD_SW |
                 (busy ? sw_q[sas_pkg::SW_SEQ +: 8] : 8'h00);

  logic unused;
  assign unused = ^{HADDR[31:9], HSIZE};
endmodule

//--- verification/sas_ana_model.sv
// Behavioural analogue front end: per-channel input codes and comparator.
// Assumes the sequencer's control bundle and the single core clock.
`timescale 1ns/100ps
module sas_ana_model (
  // Clock
  input wire logic clk,
  // Front end
  input wire sas_pkg::sas_ana_t ana,
  input wire logic [16:0][11:0] vin,
  output logic comp_hi
);
  logic [11:0] held_q = 12'h000;
  // Track while sampling, hold for the whole conversion
  always @(posedge clk) begin
    if (ana.sample) begin
      held_q <= vin[ana.mux_sel];
    end
  end
  // Moves only after an edge, since both operands are registered
  assign comp_hi = held_q >= ana.dac_code;
endmodule

//--- verification/sas_chk.sv
// Port-level checks of the converter sequencer.
// Assumes it is bound to sas_top and sees only its ports.
`timescale 1ns/100ps
module sas_chk (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RESETN,
  // Bus
  input wire logic HSEL,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  // Front end, switches, power, interrupt
  input wire sas_pkg::sas_ana_t ANA,
  input wire logic [7:0] PLD_SW,
  input wire logic [7:0] OA_SW,
  input wire logic LOW_POWER_MODE,
  input wire logic IRQ
);
  // A full conversion of 18 conversion clocks, in core clocks; one tick short
  // must already fire
  localparam int CONV_MIN = sas_pkg::CONV_CLKS * sas_pkg::CONV_DIV;
  logic [7:0] low_cnt_q;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  // Saturates, so a long idle spell counts as a full conversion
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      low_cnt_q <= 8'hFF;
    end else if (ANA.sample) begin
      low_cnt_q <= 8'h00;
    end else if (low_cnt_q != 8'hFF) begin
      low_cnt_q <= low_cnt_q + 8'h01;
    end
  end
  property p_lp_idle;
    LOW_POWER_MODE |=> !ANA.sample;
  endproperty
  a_lp_idle: assert property (p_lp_idle)
    else $error("sampling in low power");
  property p_sar_rate;
    $rose(ANA.sar_clk) |=> (!$rose(ANA.sar_clk)) [*6];
  endproperty
  a_sar_rate: assert property (p_sar_rate)
    else $error("conversion clock too fast");
  property p_conv_len;
    $rose(ANA.sample) |-> low_cnt_q >= CONV_MIN;
  endproperty
  a_conv_len: assert property (p_conv_len)
    else $error("conversion too short");
  property p_conv_start;
    $fell(ANA.sample) && !$past(LOW_POWER_MODE) |-> ANA.dac_code == 12'h800;
  endproperty
  a_conv_start: assert property (p_conv_start)
    else $error("first trial code wrong");
  property p_oa_or;
    (OA_SW & PLD_SW) == PLD_SW;
  endproperty
  a_oa_or: assert property (p_oa_or)
    else $error("logic switch request lost");
  property p_mux_hold;
    ANA.sample && $past(ANA.sample) |-> $stable(ANA.mux_sel);
  endproperty
  a_mux_hold: assert property (p_mux_hold)
    else $error("channel changed while sampling");
  property p_mux_range;
    ANA.sample |-> ANA.mux_sel <= sas_pkg::TEMP_CH;
  endproperty
  a_mux_range: assert property (p_mux_range)
    else $error("channel out of range");
  property p_rd_hold;
    !(HSEL && HTRANS[1] && !HWRITE) |=> $stable(HRDATA);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved");
  property p_bus_ok;
    HREADYOUT && !HRESP;
  endproperty
  a_bus_ok: assert property (p_bus_ok)
    else $error("bus wait or error");
  c_conv: cover property ($fell(ANA.sample));
  c_irq: cover property ($rose(IRQ));
  c_temp: cover property (ANA.sample && ANA.mux_sel == sas_pkg::TEMP_CH);
endmodule
bind sas_top sas_chk u_chk (.CORE_CLK, .RESETN, .HSEL, .HTRANS, .HWRITE,
  .HRDATA, .HREADYOUT, .HRESP, .ANA, .PLD_SW, .OA_SW, .LOW_POWER_MODE,
  .IRQ);

//--- verification/sas_top_tb.sv
// Self-checking bench for the converter sequencer.
// Assumes sas_top, the analogue model and the bound checker are compiled.
`timescale 1ns/100ps
module sas_top_tb;
  typedef struct { logic [11:0] v; logic out; } sas_row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata, rd;
  logic hready, hresp, comp_hi, irq, smp_q;
  logic lpm = 1'b0;
  logic [7:0] pld_sw = 8'h00;
  logic [7:0] oa_sw;
  logic [16:0][11:0] vin = '0;
  sas_pkg::sas_ana_t ana;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  // Limits are 0x100..0xE00; boundary codes sit on both sides
  sas_row_t rows [8] = '{'{12'h0FF, 1'b1}, '{12'h100, 1'b0},
    '{12'hE00, 1'b0}, '{12'hE01, 1'b1}, '{12'h000, 1'b1},
    '{12'hFFF, 1'b1}, '{12'h555, 1'b0}, '{12'hAAA, 1'b0}};
  logic [8:0] ra [7] = '{sas_pkg::OFF_CTRL, sas_pkg::OFF_CHEN,
    sas_pkg::OFF_LIMIT, 9'h080, sas_pkg::OFF_INTST, sas_pkg::OFF_STAT,
    9'h024};
  logic [31:0] re [7] = '{sas_pkg::CTRL_RST, sas_pkg::CHEN_RST,
    sas_pkg::LIMIT_RST, {24'h0, sas_pkg::SMP_RST}, 0, 0, 0};

  sas_top dut (.CORE_CLK(clk), .RESETN(rst_n), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
    .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
    .ANA(ana), .COMP_HI(comp_hi), .PLD_SW(pld_sw), .OA_SW(oa_sw),
    .LOW_POWER_MODE(lpm), .IRQ(irq));
  sas_ana_model u_ana (.clk(clk), .ana(ana), .vin(vin), .comp_hi(comp_hi));

  always #4 clk = ~clk;
  always @(posedge clk) begin
    smp_q <= ana.sample;
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      num_errors = num_errors + 1;
      $display("BAD %0t run did not finish", $time);
      end_of_test();
    end
  end

  task automatic end_of_test;
    $display("%0d comparisons, %0d mismatches", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, exp, input string m);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // One idle cycle first, so a read never follows a write directly
  task automatic bus(input logic w, input logic [8:0] a,
      input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {23'h0, a};
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wait_done;
    for (int i = 0; i < 2000; i++) begin
      bus(1'b0, sas_pkg::OFF_INTST, 32'h0);
      if (rd[sas_pkg::INT_DONE] === 1'b1) break;
    end
  endtask

  task automatic rise(output int t);
    for (int i = 0; i < 3000; i++) begin
      @(posedge clk);
      #1;
      if (ana.sample === 1'b1 && smp_q === 1'b0) break;
    end
    t = cycles;
  endtask

  initial begin
    int t1, t2, w;
    logic [31:0] c, rg;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    bus(1'b1, 9'h024, 32'hFFFF_FFFF);
    bus(1'b1, sas_pkg::OFF_STAT, 32'hFFFF_FFFF);
    for (int i = 0; i < 7; i++) begin
      bus(1'b0, ra[i], 32'h0);
      chk(rd, re[i], "reset or unmapped value");
    end
    chk({31'h0, irq}, 32'h0, "irq after reset");
    $display("reset test done");
    // Table scan: eight channels plus channel 9 without the extension
    for (int i = 0; i < 8; i++) vin[i] <= rows[i].v;
    vin[9] <= 12'h123;
    pld_sw <= 8'h80;
    bus(1'b1, sas_pkg::OFF_LIMIT, 32'h0E00_0100);
    bus(1'b1, sas_pkg::OFF_CHEN, 32'h0000_02FF);
    bus(1'b1, sas_pkg::OFF_INTEN, 32'h2);
    bus(1'b1, sas_pkg::OFF_SWITCH, 32'h0000_0401);
    bus(1'b1, sas_pkg::OFF_CTRL, 32'h1);
    bus(1'b1, sas_pkg::OFF_CTRL, 32'h3);
    for (int i = 0; i < 3000 && irq !== 1'b1; i++) @(posedge clk);
    chk({24'h0, oa_sw}, 32'h85, "switches while busy");
    bus(1'b0, sas_pkg::OFF_STAT, 32'h0);
    chk({31'h0, rd[0]}, 32'h1, "irq before scan end");
    wait_done();
    chk({24'h0, oa_sw}, 32'h81, "switches idle");
    bus(1'b0, sas_pkg::OFF_RANGE, 32'h0);
    rg = rd;
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, 9'h100 + 9'(4 * i), 32'h0);
      chk(rd, {1'b1, 19'h0, rows[i].v}, "result");
      chk({31'h0, rg[i]}, {31'h0, rows[i].out}, "range flag");
    end
    bus(1'b0, 9'h124, 32'h0);
    chk(rd, 32'h0, "channel 9 skipped");
    bus(1'b0, sas_pkg::OFF_INTST, 32'h0);
    chk(rd, 32'h3, "scan status");
    // Extension on: channel 9 now joins the scan
    bus(1'b1, sas_pkg::OFF_INTCLR, 32'h1);
    bus(1'b1, sas_pkg::OFF_CTRL, 32'h0000_1001);
    bus(1'b1, sas_pkg::OFF_CTRL, 32'h0000_1003);
    wait_done();
    bus(1'b0, 9'h124, 32'h0);
    chk(rd, 32'h8000_0123, "channel 9 with extension");
    $display("scan test done");
    // Mask, unmask and clear the interrupt
    bus(1'b1, sas_pkg::OFF_INTEN, 32'h0);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0, "irq masked");
    bus(1'b1, sas_pkg::OFF_INTEN, 32'h3);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1, "irq enabled");
    bus(1'b1, sas_pkg::OFF_INTCLR, 32'h3);
    bus(1'b1, sas_pkg::OFF_RANGE, 32'hFFFF_FFFF);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    bus(1'b0, sas_pkg::OFF_RANGE, 32'h0);
    chk(rd, 32'h0, "range flags cleared");
    $display("interrupt test done");
    // Continuous single channel: restart spacing, then abort
    bus(1'b1, sas_pkg::OFF_CHEN, 32'h1);
    bus(1'b1, sas_pkg::OFF_CTRL, 32'h5);
    bus(1'b1, sas_pkg::OFF_CTRL, 32'h7);
    rise(t1);
    rise(t2);
    chk(32'(t2 - t1), 32'((int'(sas_pkg::SMP_RST) + sas_pkg::CONV_CLKS)
      * sas_pkg::CONV_DIV), "restart spacing");
    bus(1'b1, sas_pkg::OFF_INTCLR, 32'h3);
    repeat (30) @(posedge clk);
    lpm <= 1'b1;
    repeat (200) @(posedge clk);
    #1;
    chk({31'h0, ana.sample}, 32'h0, "sampling in low power");
    bus(1'b0, sas_pkg::OFF_STAT, 32'h0);
    chk({31'h0, rd[0]}, 32'h0, "busy in low power");
    bus(1'b0, sas_pkg::OFF_INTST, 32'h0);
    chk(rd, 32'h0, "done after abort");
    @(posedge clk);
    lpm <= 1'b0;
    $display("continuous test done");
    // Firmware-selected temperature channel under each reference
    vin[16] <= 12'h7A5;
    bus(1'b1, 9'h0C0, 32'hA);
    for (int r = 0; r < 4; r++) begin
      c = 32'h0000_0909 | (32'h10 << 4) | (32'(r) << 9);
      bus(1'b1, sas_pkg::OFF_CTRL, c);
      bus(1'b1, sas_pkg::OFF_CTRL, c | 32'h2);
      #1;
      chk({23'h0, ana.sample, ana.mux_sel, ana.ref_sel, ana.temp_bias_en},
        {23'h0, 1'b1, 5'h10, 2'(r), 1'b1}, "front end");
      w = 0;
      while (ana.sample === 1'b1 && w < 500) begin
        @(posedge clk);
        #1;
        w++;
      end
      chk(32'(w >= 60 && w <= 70), 32'h1, "sample window");
      wait_done();
      bus(1'b0, 9'h140, 32'h0);
      chk(rd, 32'h8000_07A5, "temperature result");
      bus(1'b1, sas_pkg::OFF_INTCLR, 32'h3);
    end
    $display("firmware test done");
    // Reset in mid-sample: registers, results and interrupt go back
    bus(1'b1, sas_pkg::OFF_CTRL, c | 32'h2);
    repeat (20) @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk({31'h0, ana.sample}, 32'h0, "sampling after reset");
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0, "irq after mid-run reset");
    bus(1'b0, sas_pkg::OFF_CTRL, 32'h0);
    chk(rd, sas_pkg::CTRL_RST, "control after mid-run reset");
    bus(1'b0, 9'h140, 32'h0);
    chk(rd, 32'h0, "result after mid-run reset");
    bus(1'b0, sas_pkg::OFF_STAT, 32'h0);
    chk(rd, 32'h0, "status after mid-run reset");
    $display("mid-run reset test done");
    end_of_test();
  end
endmodule
